// ### sac_step_atten_regs.vh
// Register map, field positions and reset values of the step attenuator control block
`ifndef SAC_STEP_ATTEN_REGS_VH
`define SAC_STEP_ATTEN_REGS_VH

// Register byte offsets
`define SAC_OFF_CTRL 8'h00
`define SAC_OFF_SWATT 8'h04
`define SAC_OFF_STATUS 8'h08
`define SAC_OFF_COUNT 8'h0c

// Register select codes returned by the address decoder
`define SAC_SEL_NONE 3'h0
`define SAC_SEL_CTRL 3'h1
`define SAC_SEL_SWATT 3'h2
`define SAC_SEL_STATUS 3'h3
`define SAC_SEL_COUNT 3'h4

// Field positions
`define SAC_CTRL_OVR_BIT 0
`define SAC_STAT_SERIAL_BIT 8
`define SAC_STAT_DIRECT_BIT 9
`define SAC_STAT_ADDR_LSB 10
`define SAC_COUNT_MISS_LSB 16
`define SAC_FRM_DATA_LSB 0
`define SAC_FRM_ADDR_LSB 8

// Widths
`define SAC_ATTEN_W 7
`define SAC_FRAME_W 16
`define SAC_CNT_W 16

// Reset and power-up values
`define SAC_ATTEN_MAX 7'h7f
`define SAC_CTRL_RST 1'b0
`define SAC_SWATT_RST 7'h7f
`define SAC_CNT_RST 16'h0000

// Bus responses
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2

`endif

// ### sac_serial_rx.v
// Serial frame receiver with strapped address match
`timescale 1ns/1ps
module sac_serial_rx (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Serial pins
	input wire serialClk,
	input wire serialData,
	input wire serialMode,
	input wire [2:0] addrStrap,
	input wire loadEdge,
	// Frame result
	output reg [6:0] frameWord,
	output reg frameHit,
	output reg frameMiss
);
`include "sac_step_atten_regs.vh"

reg serialClkPrev;
reg [`SAC_FRAME_W-1:0] shiftReg;
wire clkRise;
wire addrMatch;

assign clkRise = serialClk & ~serialClkPrev;
assign addrMatch = (shiftReg[`SAC_FRM_ADDR_LSB+2:`SAC_FRM_ADDR_LSB] == addrStrap);

always @(posedge mclk) begin
	if (rst) begin
		serialClkPrev <= 1'b0;
		shiftReg <= {`SAC_FRAME_W{1'b0}};
		frameWord <= `SAC_ATTEN_MAX;
		frameHit <= 1'b0;
		frameMiss <= 1'b0;
	end else begin
		serialClkPrev <= serialClk;
		// Shift only in serial mode so parallel traffic cannot leave a stale frame
		if (serialMode && clkRise) begin
			shiftReg <= {shiftReg[`SAC_FRAME_W-2:0], serialData};
		end
		frameHit <= serialMode & loadEdge & addrMatch;
		frameMiss <= serialMode & loadEdge & ~addrMatch;
		if (serialMode && loadEdge && addrMatch) begin
			frameWord <= shiftReg[`SAC_FRM_DATA_LSB+6:`SAC_FRM_DATA_LSB];
		end
	end
end

endmodule // sac_serial_rx

// ### sac_step_atten.v
// Step attenuator control: pin modes, power-up state and AXI4-Lite registers
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module sac_step_atten (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Mode and strobe pins
	input wire serialParallelSelect,
	input wire latchStrobe,
	// Address straps
	input wire addrPin0,
	input wire addrPin1,
	input wire addrPin2,
	// Serial pins
	input wire serialClk,
	input wire serialData,
	// Parallel control pins
	input wire step16db,
	input wire step8db,
	input wire step4db,
	input wire step2db,
	input wire step1db,
	input wire stepHalfDb,
	// Attenuation state
	output reg [6:0] attenWord,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
`include "sac_step_atten_regs.vh"

localparam [1:0] ST_POWERUP = 2'b01;
localparam [1:0] ST_RUN = 2'b10;

// Word-aligned decode; byte lanes below bit 2 are ignored
function [2:0] regSelect;
	input [7:0] addr;
	begin
		case ({addr[7:2], 2'b00})
			`SAC_OFF_CTRL: regSelect = `SAC_SEL_CTRL;
			`SAC_OFF_SWATT: regSelect = `SAC_SEL_SWATT;
			`SAC_OFF_STATUS: regSelect = `SAC_SEL_STATUS;
			`SAC_OFF_COUNT: regSelect = `SAC_SEL_COUNT;
			default: regSelect = `SAC_SEL_NONE;
		endcase
	end
endfunction

reg [1:0] state_reg;
reg [1:0] state_next;
reg [6:0] atten_next;
reg latchPrev_reg;
reg ctrlOvr_reg;
reg [6:0] swAtten_reg;
reg [`SAC_CNT_W-1:0] loadCount_reg;
reg [`SAC_CNT_W-1:0] missCount_reg;
reg [7:0] awAddr_reg;
reg awHeld_reg;
reg [31:0] wData_reg;
reg [3:0] wStrb_reg;
reg wHeld_reg;
reg [31:0] readValue;

wire serialMode;
wire directMode;
wire latchRise;
wire [6:0] parallelWord;
wire [5:0] stepPins;
wire [2:0] addrStrap;
wire [6:0] frameWord;
wire frameHit;
wire frameMiss;
wire parallelLoad;
wire doWrite;
wire [2:0] wrSel;
wire [2:0] rdSel;

assign serialMode = serialParallelSelect;
assign directMode = ~serialParallelSelect & latchStrobe;
assign latchRise = latchStrobe & ~latchPrev_reg;
// Pin group runs from the half step up, so pin g lands on word bit g+1
assign stepPins = {step16db, step8db, step4db, step2db, step1db, stepHalfDb};
// The quarter step has no parallel pin, so parallel words are always even
assign parallelWord[0] = 1'b0;
genvar g;
generate
	for (g = 0; g < 6; g = g + 1) begin : gWeight
		// Each line inserts only its own weight
		assign parallelWord[g + 1] = stepPins[g];
	end
endgenerate
assign addrStrap = {addrPin2, addrPin1, addrPin0};
assign parallelLoad = ~serialParallelSelect & latchRise;
assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
assign wrSel = regSelect(awAddr_reg);
assign rdSel = regSelect(s_axi_araddr);

sac_serial_rx serialRx (
	.mclk(mclk),
	.rst(rst),
	.serialClk(serialClk),
	.serialData(serialData),
	.serialMode(serialMode),
	.addrStrap(addrStrap),
	.loadEdge(latchRise),
	.frameWord(frameWord),
	.frameHit(frameHit),
	.frameMiss(frameMiss)
);

// Attenuation state selection
always @* begin
	state_next = state_reg;
	atten_next = attenWord;
	case (state_reg)
		ST_POWERUP: begin
			// Strobe is low here, so the lines are read as a power-up strap
			if (parallelWord != 7'h00) begin
				atten_next = parallelWord;
			end else begin
				atten_next = `SAC_ATTEN_MAX;
			end
			state_next = ST_RUN;
		end
		ST_RUN: begin
			// Override wins over every pin load so software can park the attenuator
			if (ctrlOvr_reg) begin
				atten_next = swAtten_reg;
			end else if (frameHit) begin
				atten_next = frameWord;
			end else if (parallelLoad) begin
				atten_next = parallelWord;
			end else if (directMode) begin
				atten_next = parallelWord;
			end
		end
		default: begin
			state_next = ST_POWERUP;
			atten_next = `SAC_ATTEN_MAX;
		end
	endcase
end

always @(posedge mclk) begin
	if (rst) begin
		state_reg <= ST_POWERUP;
		attenWord <= `SAC_ATTEN_MAX;
		latchPrev_reg <= 1'b0;
	end else begin
		state_reg <= state_next;
		attenWord <= atten_next;
		latchPrev_reg <= latchStrobe;
	end
end

// Load and reject counters wrap; they are for field diagnosis only
always @(posedge mclk) begin
	if (rst) begin
		loadCount_reg <= `SAC_CNT_RST;
		missCount_reg <= `SAC_CNT_RST;
	end else if (state_reg == ST_RUN) begin
		if (frameHit || parallelLoad) begin
			loadCount_reg <= loadCount_reg + 16'h0001;
		end
		if (frameMiss) begin
			missCount_reg <= missCount_reg + 16'h0001;
		end
	end
end

// Write channels are taken independently and joined before the response
// No new address or data is taken while a response waits, so none is lost
always @(posedge mclk) begin
	if (rst) begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		awHeld_reg <= 1'b0;
		wHeld_reg <= 1'b0;
		awAddr_reg <= 8'h00;
		wData_reg <= 32'h00000000;
		wStrb_reg <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `SAC_RESP_OKAY;
	end else begin
		s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~awHeld_reg & ~s_axi_bvalid;
		s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~wHeld_reg & ~s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			awAddr_reg <= s_axi_awaddr;
			awHeld_reg <= 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wData_reg <= s_axi_wdata;
			wStrb_reg <= s_axi_wstrb;
			wHeld_reg <= 1'b1;
		end
		if (doWrite) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			s_axi_bvalid <= 1'b1;
			if (wrSel == `SAC_SEL_NONE) begin
				s_axi_bresp <= `SAC_RESP_SLVERR;
			end else begin
				s_axi_bresp <= `SAC_RESP_OKAY;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// Software registers; read-only registers silently ignore writes
always @(posedge mclk) begin
	if (rst) begin
		ctrlOvr_reg <= `SAC_CTRL_RST;
		swAtten_reg <= `SAC_SWATT_RST;
	end else if (doWrite && wStrb_reg[0]) begin
		if (wrSel == `SAC_SEL_CTRL) begin
			ctrlOvr_reg <= wData_reg[`SAC_CTRL_OVR_BIT];
		end
		if (wrSel == `SAC_SEL_SWATT) begin
			swAtten_reg <= wData_reg[6:0];
		end
	end
end

// Read data mux
always @* begin
	readValue = 32'h00000000;
	case (rdSel)
		`SAC_SEL_CTRL: readValue[`SAC_CTRL_OVR_BIT] = ctrlOvr_reg;
		`SAC_SEL_SWATT: readValue[6:0] = swAtten_reg;
		`SAC_SEL_STATUS: begin
			readValue[6:0] = attenWord;
			readValue[`SAC_STAT_SERIAL_BIT] = serialMode;
			readValue[`SAC_STAT_DIRECT_BIT] = directMode;
			readValue[`SAC_STAT_ADDR_LSB+2:`SAC_STAT_ADDR_LSB] = addrStrap;
		end
		`SAC_SEL_COUNT: begin
			readValue[`SAC_CNT_W-1:0] = loadCount_reg;
			readValue[`SAC_COUNT_MISS_LSB+15:`SAC_COUNT_MISS_LSB] = missCount_reg;
		end
		default: readValue = 32'h00000000;
	endcase
end

// Read data is captured at the address handshake; later changes are not seen
always @(posedge mclk) begin
	if (rst) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `SAC_RESP_OKAY;
	end else begin
		s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= readValue;
			if (rdSel == `SAC_SEL_NONE) begin
				s_axi_rresp <= `SAC_RESP_SLVERR;
			end else begin
				s_axi_rresp <= `SAC_RESP_OKAY;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule // sac_step_atten

// ### sac_step_atten_sva.sv
// Assertions on the attenuator pins and the register read handshake
`timescale 1ns/1ps
module sac_step_atten_sva (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Pins
	input wire serialParallelSelect,
	input wire latchStrobe,
	input wire step16db,
	input wire step8db,
	input wire step4db,
	input wire step2db,
	input wire step1db,
	input wire stepHalfDb,
	input wire [6:0] attenWord,
	// Read channel
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	wire [6:0] pw = {step16db, step8db, step4db, step2db, step1db, stepHalfDb, 1'b0};
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence quiet_s; !latchStrobe [*3]; endsequence
	// Three steady edges let any earlier strobe load settle first
	sequence direct_s; (!serialParallelSelect && latchStrobe && $stable(pw)) [*3]; endsequence
	a_reset_max: assert property (disable iff (1'b0) rst ##1 rst
		|-> attenWord == 7'h7f) else $error("not max in reset");
	a_powerup_word: assert property ($fell(rst) && pw != 7'h00
		|=> attenWord == $past(pw)) else $error("power-up word lost");
	a_powerup_max: assert property ($fell(rst) && pw == 7'h00
		|=> attenWord == 7'h7f) else $error("power-up not max");
	a_latch_load: assert property (!serialParallelSelect && $rose(latchStrobe)
		|-> ##[1:2] attenWord == pw) else $error("latched load wrong");
	a_direct_follow: assert property (direct_s
		|=> attenWord == $past(pw)) else $error("direct mode not followed");
	a_latch_quiet: assert property (quiet_s
		|=> $stable(attenWord)) else $error("change without strobe");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read data late");
	a_read_clear: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid) else $error("read data not cleared");
endmodule // sac_step_atten_sva
bind sac_step_atten sac_step_atten_sva u_sva (.*);

// ### sac_ctl_model.sv
// Controller model driving mode, strobe, serial and parallel pins
`timescale 1ns/1ps
module sac_ctl_model (
	// Clock
	input wire mclk,
	// Mode and strobe
	output reg serialParallelSelect,
	output reg latchStrobe,
	// Serial lines
	output reg serialClk,
	output reg serialData,
	// Parallel lines, 16 dB first
	output reg [5:0] steps
);
	integer k;
	initial begin
		{serialParallelSelect, latchStrobe, serialClk, serialData, steps} = 10'h000;
	end
	task mode(input s, input l);
		begin
			@(posedge mclk);
			serialParallelSelect <= s;
			latchStrobe <= l;
		end
	endtask
	task lines(input [5:0] w);
		begin
			@(posedge mclk);
			steps <= w;
		end
	endtask
	// Word must already sit on the lines
	task pulse;
		begin
			@(posedge mclk);
			latchStrobe <= 1'b1;
			@(posedge mclk);
			latchStrobe <= 1'b0;
		end
	endtask
	// Clock idles low; data is scrambled after a frame
	task frame(input [15:0] f);
		begin
			for (k = 15; k >= 0; k = k - 1) begin
				@(posedge mclk);
				serialClk <= 1'b0;
				serialData <= f[k];
				@(posedge mclk);
				serialClk <= 1'b1;
			end
			@(posedge mclk);
			serialClk <= 1'b0;
			serialData <= ~f[0];
			pulse;
		end
	endtask
endmodule // sac_ctl_model

// ### step_attenuator_control_bench.sv
// Self-checking bench for the step attenuator control block
`timescale 1ns/1ps
module step_attenuator_control_bench;
	reg mclk, rst, addrPin0, addrPin1, addrPin2;
	reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg [7:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata, rd;
	reg [2:0] s_axi_awprot, s_axi_arprot;
	reg [3:0] s_axi_wstrb;
	reg [1:0] rsp;
	wire serialParallelSelect, latchStrobe, serialClk, serialData;
	wire step16db, step8db, step4db, step2db, step1db, stepHalfDb;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [6:0] attenWord;
	wire [5:0] steps;
	integer errTotal, numChecks, i;
	assign {step16db, step8db, step4db, step2db, step1db, stepHalfDb} = steps;
	sac_step_atten dut (.*);
	sac_ctl_model u_ctl (.*);
	task chk(input string n, input [31:0] e, input [31:0] g);
		begin
			numChecks = numChecks + 1;
			if (g !== e) begin
				errTotal = errTotal + 1;
				$display("Error %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [3:0] s);
		begin
			@(posedge mclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_wstrb <= s;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
			// Each valid drops at the edge that sees its own ready
			do begin
				@(posedge mclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (!s_axi_bvalid);
			rsp = s_axi_bresp;
			s_axi_bready <= 1'b0;
		end
	endtask
	task rdr(input [7:0] a);
		begin
			@(posedge mclk);
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
			do begin
				@(posedge mclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (!s_axi_rvalid);
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
	task tPowerUp;
		begin
			u_ctl.lines(6'h2b);
			repeat (7) @(posedge mclk);
			chk("atten", 32'h7f, attenWord);
			rst <= 1'b0;
			repeat (3) @(posedge mclk);
			chk("atten", 32'h56, attenWord);
			u_ctl.lines(6'h00);
			rst <= 1'b1;
			repeat (8) @(posedge mclk);
			rst <= 1'b0;
			repeat (3) @(posedge mclk);
			chk("atten", 32'h7f, attenWord);
		end
	endtask
	// Lines move while the strobe is low: the loaded word must hold
	task tLatched;
		for (i = 0; i < 6; i = i + 1) begin
			u_ctl.lines(6'h01 << i);
			u_ctl.pulse;
			repeat (3) @(posedge mclk);
			u_ctl.lines(~(6'h01 << i));
			repeat (3) @(posedge mclk);
			chk("atten", {6'h01 << i, 1'b0}, attenWord);
		end
	endtask
	task tDirect;
		begin
			u_ctl.mode(1'b0, 1'b1);
			repeat (3) @(posedge mclk);
			u_ctl.lines(6'h15);
			repeat (3) @(posedge mclk);
			chk("atten", 32'h2a, attenWord);
		end
	endtask
	task tSerial;
		begin
			u_ctl.mode(1'b1, 1'b0);
			u_ctl.frame(16'h0433);
			repeat (4) @(posedge mclk);
			chk("atten", 32'h33, attenWord);
			u_ctl.frame(16'h0311);
			repeat (4) @(posedge mclk);
			chk("atten", 32'h33, attenWord);
			{addrPin2, addrPin1, addrPin0} <= 3'h3;
			u_ctl.frame(16'h0311);
			repeat (4) @(posedge mclk);
			chk("atten", 32'h11, attenWord);
		end
	endtask
	task tRegs;
		begin
			rdr(8'h00);
			chk("ctrl", 32'h0, rd);
			rdr(8'h04);
			chk("swatt", 32'h7f, rd);
			rdr(8'h08);
			chk("status", 32'h0d11, rd);
			rdr(8'h0c);
			chk("misses", 32'h1, rd >> 16);
			chk("loads", 32'h9, rd & 32'hffff);
			rdr(8'h10);
			chk("rresp", 32'h2, rsp);
			chk("rdata", 32'h0, rd);
			wr(8'h14, 32'h1, 4'hf);
			chk("bresp", 32'h2, rsp);
			wr(8'h04, 32'h4c, 4'hf);
			chk("bresp", 32'h0, rsp);
			wr(8'h04, 32'h11, 4'he);
			chk("bresp", 32'h0, rsp);
			rdr(8'h04);
			chk("swatt", 32'h4c, rd);
			chk("rresp", 32'h0, rsp);
			u_ctl.mode(1'b1, 1'b1);
			wr(8'h00, 32'h1, 4'hf);
			repeat (3) @(posedge mclk);
			chk("atten", 32'h4c, attenWord);
		end
	endtask
	task summarize;
		begin
			if (errTotal == 0 && numChecks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge mclk);
		errTotal = errTotal + 1;
		summarize;
	end
	initial begin
		errTotal = 0;
		numChecks = 0;
		rst = 1'b1;
		{addrPin2, addrPin1, addrPin0} = 3'h4;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00f;
		tPowerUp;
		tLatched;
		tDirect;
		tSerial;
		tRegs;
		summarize;
	end
endmodule // step_attenuator_control_bench
